/* File: rtl/ee2w_cond_det.sv */
// Purpose: Catches start and stop conditions on the data line.
// Assumes: Data only moves while the bus clock is low, except for
//          conditions.
// Notes: Each condition flips a toggle; readers compare against a copy.
`timescale 1ns/100ps

module ee2w_cond_det import ee2w_pkg::*; (
  // Reset
  input wire logic i_sys_rst,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda_in,
  // Condition toggles
  output ee2w_cond_t o_cond
);

  logic start_tgl_ff;
  logic stop_tgl_ff;

  // Falling data with clock high can only be a start
  always_ff @(negedge i_sda_in or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      start_tgl_ff <= 1'b0;
    end else if (i_scl) begin
      start_tgl_ff <= ~start_tgl_ff; // see R2 see R1
    end
  end

  // Rising data with clock high can only be a stop
  always_ff @(posedge i_sda_in or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stop_tgl_ff <= 1'b0;
    end else if (i_scl) begin
      stop_tgl_ff <= ~stop_tgl_ff; // see R3 see R1
    end
  end

  assign o_cond = '{start_tgl: start_tgl_ff, stop_tgl: stop_tgl_ff};

endmodule

/* File: rtl/ee2w_target.sv */
// Purpose: Two-wire serial EEPROM target: addressing, acknowledge,
//          byte and page write, reads and the self-timed write cycle.
// Assumes: i_scl is the bus clock; data pins obey bus protocol, so
//          they are stable around the clock edges that read them.
// Notes: Link logic on the bus clock, write timer on i_clock.
`timescale 1ns/100ps

module ee2w_target import ee2w_pkg::*; #(
  parameter int unsigned WR_CYCLES = WRITE_CYCLES
) (
  // System clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  // Strap and protect pins
  input wire logic [1:0] i_device_select_straps,
  input wire logic i_write_protect,
  // Status
  output logic o_write_busy,
  output logic o_link_active
);

  ee2w_cond_t cond;
  ee2w_link_t link_ff;
  ee2w_link_t nxt_link;
  ee2w_sys_t sys_ff;
  ee2w_sys_t nxt_sys;
  logic sda_pos_ff;
  logic [7:0] mem_q [0:MEM_BYTES-1];
  logic [7:0] rx_byte_c;
  logic [7:0] rd_byte_c;
  logic start_ev_c;
  logic stop_ev_c;
  logic dev_match_c;
  logic wr_en_c;
  logic sys_stop_c;

  ee2w_cond_det u_cond (
    .i_sys_rst (i_sys_rst),
    .i_scl     (i_scl),
    .i_sda_in  (i_sda_in),
    .o_cond    (cond)
  );

  // Incoming bits are taken on the rising clock
  always_ff @(posedge i_scl) begin
    sda_pos_ff <= i_sda_in; // see R22
  end

  // Array; its contents are not reset, like a real cell array
  always_ff @(negedge i_scl) begin
    if (wr_en_c) begin
      mem_q[link_ff.addr] <= rx_byte_c; // see R23
    end
  end

  assign rd_byte_c = mem_q[link_ff.addr];

  always_comb begin
    nxt_link = link_ff;
    wr_en_c = 1'b0;
    rx_byte_c = {link_ff.rx_sh[6:0], sda_pos_ff}; // see R25
    start_ev_c = cond.start_tgl != link_ff.start_seen;
    stop_ev_c = cond.stop_tgl != link_ff.stop_seen;
    dev_match_c =
      rx_byte_c[7:DEV_PAT_LSB] == DEV_PATTERN && // see R7
      rx_byte_c[DEV_PAT_LSB-1:DEV_SEL_LSB] ==
        link_ff.sync2.straps && // see R8
      !link_ff.sync2.busy; // see R13 see R16
    nxt_link.sync1 = '{busy: sys_ff.busy, wp: i_write_protect,
                       straps: i_device_select_straps};
    nxt_link.sync2 = link_ff.sync1;
    nxt_link.start_seen = cond.start_tgl;
    nxt_link.stop_seen = cond.stop_tgl;
    nxt_link.sda_out = 1'b0;
    if (start_ev_c) begin
      // A start wins over a stop seen in the same high phase
      nxt_link.state = ST_DEV; // see R2
      nxt_link.bit_cnt = 3'h0;
      nxt_link.sda_oe_n = 1'b1;
      nxt_link.first_data = 1'b1;
      nxt_link.active = 1'b1;
    end else if (stop_ev_c) begin
      nxt_link.state = ST_IDLE; // see R3 see R5
      nxt_link.sda_oe_n = 1'b1;
      nxt_link.active = 1'b0;
    end else begin
      case (link_ff.state)
        ST_IDLE: begin
          nxt_link.sda_oe_n = 1'b1;
          nxt_link.active = 1'b0;
        end
        ST_DEV: begin
          nxt_link.rx_sh = rx_byte_c;
          nxt_link.bit_cnt = link_ff.bit_cnt + 3'h1;
          if (link_ff.bit_cnt == LAST_BIT) begin
            if (dev_match_c) begin
              nxt_link.sda_oe_n = 1'b0; // see R4 see R10
              nxt_link.rw = rx_byte_c[DEV_RW_BIT]; // see R9
              nxt_link.state = ST_DEV_ACK;
            end else begin
              nxt_link.state = ST_IDLE; // see R10
              nxt_link.active = 1'b0;
            end
          end
        end
        ST_DEV_ACK: begin
          nxt_link.bit_cnt = 3'h0;
          if (link_ff.rw) begin
            // First read bit goes out as the ack clock ends
            nxt_link.sda_oe_n = rd_byte_c[7]; // see R19 see R22
            nxt_link.tx_sh = {rd_byte_c[6:0], 1'b1};
            nxt_link.state = ST_RDAT;
          end else begin
            nxt_link.sda_oe_n = 1'b1;
            nxt_link.state = ST_AHI; // see R12
          end
        end
        ST_AHI: begin
          nxt_link.rx_sh = rx_byte_c;
          nxt_link.bit_cnt = link_ff.bit_cnt + 3'h1;
          if (link_ff.bit_cnt == LAST_BIT) begin
            nxt_link.addr_hi = rx_byte_c; // see R26
            nxt_link.sda_oe_n = 1'b0; // see R4
            nxt_link.state = ST_AHI_ACK;
          end
        end
        ST_AHI_ACK: begin
          nxt_link.sda_oe_n = 1'b1;
          nxt_link.bit_cnt = 3'h0;
          nxt_link.state = ST_ALO;
        end
        ST_ALO: begin
          nxt_link.rx_sh = rx_byte_c;
          nxt_link.bit_cnt = link_ff.bit_cnt + 3'h1;
          if (link_ff.bit_cnt == LAST_BIT) begin
            // Loading here also serves the dummy write of a random read
            nxt_link.addr = {link_ff.addr_hi, rx_byte_c}; // see R20
            nxt_link.sda_oe_n = 1'b0; // see R4
            nxt_link.state = ST_ALO_ACK;
          end
        end
        ST_ALO_ACK: begin
          nxt_link.sda_oe_n = 1'b1;
          nxt_link.bit_cnt = 3'h0;
          nxt_link.state = ST_WDAT;
        end
        ST_WDAT: begin
          nxt_link.rx_sh = rx_byte_c;
          nxt_link.bit_cnt = link_ff.bit_cnt + 3'h1;
          if (link_ff.bit_cnt == LAST_BIT) begin
            // Protected writes are still acked but never land
            wr_en_c = !link_ff.sync2.wp; // see R11 see R24
            if (!link_ff.sync2.wp && link_ff.first_data) begin
              nxt_link.wr_tgl = ~link_ff.wr_tgl; // see R13
              nxt_link.first_data = 1'b0;
            end
            nxt_link.addr = {link_ff.addr[ADDR_W-1:PAGE_BITS],
              link_ff.addr[PAGE_BITS-1:0] + 7'h01}; // see R15 see R14
            nxt_link.sda_oe_n = 1'b0; // see R4 see R12
            nxt_link.state = ST_WDAT_ACK;
          end
        end
        ST_WDAT_ACK: begin
          nxt_link.sda_oe_n = 1'b1;
          nxt_link.bit_cnt = 3'h0;
          nxt_link.state = ST_WDAT;
        end
        ST_RDAT: begin
          nxt_link.bit_cnt = link_ff.bit_cnt + 3'h1;
          if (link_ff.bit_cnt == LAST_BIT) begin
            nxt_link.sda_oe_n = 1'b1;
            nxt_link.addr = link_ff.addr + 16'h0001; // see R17 see R18
            nxt_link.state = ST_RD_MACK;
          end else begin
            nxt_link.sda_oe_n = link_ff.tx_sh[7]; // see R25
            nxt_link.tx_sh = {link_ff.tx_sh[6:0], 1'b1};
          end
        end
        ST_RD_MACK: begin
          nxt_link.bit_cnt = 3'h0;
          if (!sda_pos_ff) begin
            nxt_link.sda_oe_n = rd_byte_c[7]; // see R21
            nxt_link.tx_sh = {rd_byte_c[6:0], 1'b1};
            nxt_link.state = ST_RDAT;
          end else begin
            // No ack: let go and wait for the stop
            nxt_link.sda_oe_n = 1'b1; // see R19
            nxt_link.state = ST_IDLE;
            // Cleared here, as the clock may stand still after the stop
            nxt_link.active = 1'b0; // see R3
          end
        end
        default: begin
          nxt_link.state = ST_IDLE;
          nxt_link.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // The bus clock may be stopped during reset, so reset acts at once
  always_ff @(negedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      link_ff <= LINK_RST; // see R5
    end else begin
      link_ff <= nxt_link;
    end
  end

  // Write timer on the system clock
  always_comb begin
    nxt_sys = sys_ff;
    nxt_sys.stop_s1 = cond.stop_tgl;
    nxt_sys.stop_s2 = sys_ff.stop_s1;
    nxt_sys.wr_s1 = link_ff.wr_tgl;
    nxt_sys.wr_s2 = sys_ff.wr_s1;
    nxt_sys.stop_seen = sys_ff.stop_s2;
    sys_stop_c = sys_ff.stop_s2 != sys_ff.stop_seen;
    if (sys_ff.busy) begin
      if (sys_ff.timer == 32'h0000_0000) begin
        nxt_sys.busy = 1'b0; // see R5
      end else begin
        nxt_sys.timer = sys_ff.timer - 32'h0000_0001;
      end
    end else if (sys_stop_c && sys_ff.wr_s2 != sys_ff.wr_seen) begin
      // Stop after accepted data launches the write cycle
      nxt_sys.busy = 1'b1; // see R13
      nxt_sys.timer = 32'(WR_CYCLES - 1);
      nxt_sys.wr_seen = sys_ff.wr_s2;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sys_ff <= SYS_RST;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  assign o_sda_out = link_ff.sda_out;
  assign o_sda_oe_n = link_ff.sda_oe_n;
  assign o_link_active = link_ff.active;
  assign o_write_busy = sys_ff.busy;

  // Checks on the link side

  sequence dev_byte_s;
    link_ff.state == ST_DEV && link_ff.bit_cnt == LAST_BIT &&
      !start_ev_c && !stop_ev_c;
  endsequence

  sequence ack_slot_s;
    !link_ff.sda_oe_n && link_ff.state == ST_DEV_ACK;
  endsequence

  dev_ack_a: assert property ( // see R10
    @(negedge i_scl) disable iff (i_sys_rst)
    dev_byte_s and dev_match_c |=> ack_slot_s ##1 (link_ff.sda_oe_n ||
      link_ff.rw))
    else $error("matched device word not acked");

  dev_nack_a: assert property ( // see R10
    @(negedge i_scl) disable iff (i_sys_rst)
    dev_byte_s and !dev_match_c |=>
      link_ff.sda_oe_n && link_ff.state == ST_IDLE)
    else $error("unmatched device word acked");

  busy_silent_a: assert property ( // see R16
    @(negedge i_scl) disable iff (i_sys_rst)
    dev_byte_s and link_ff.sync2.busy |=> link_ff.sda_oe_n)
    else $error("acked while write cycle runs");

  page_wrap_a: assert property ( // see R15
    @(negedge i_scl) disable iff (i_sys_rst)
    link_ff.state == ST_WDAT && link_ff.bit_cnt == LAST_BIT &&
      !start_ev_c && !stop_ev_c |=>
      link_ff.addr[15:7] == $past(link_ff.addr[15:7]) &&
      link_ff.addr[6:0] == $past(link_ff.addr[6:0]) + 7'h01)
    else $error("page address step wrong");

  read_step_a: assert property ( // see R18
    @(negedge i_scl) disable iff (i_sys_rst)
    link_ff.state == ST_RDAT && link_ff.bit_cnt == LAST_BIT &&
      !start_ev_c && !stop_ev_c |=>
      link_ff.addr == $past(link_ff.addr) + 16'h0001 &&
      link_ff.state == ST_RD_MACK && link_ff.sda_oe_n)
    else $error("read address step wrong");

  wp_block_a: assert property ( // see R11
    @(negedge i_scl) disable iff (i_sys_rst)
    wr_en_c |-> !link_ff.sync2.wp && link_ff.state == ST_WDAT)
    else $error("array written while protected");

  wp_no_cycle_a: assert property ( // see R11
    @(negedge i_scl) disable iff (i_sys_rst)
    link_ff.sync2.wp |-> !wr_en_c ##1
      link_ff.wr_tgl == $past(link_ff.wr_tgl))
    else $error("write cycle launched while protected");

  start_restart_a: assert property ( // see R2
    @(negedge i_scl) disable iff (i_sys_rst)
    start_ev_c |=> link_ff.state == ST_DEV && link_ff.bit_cnt == 3'h0
      && link_ff.sda_oe_n)
    else $error("start did not restart link");

  stop_idle_a: assert property ( // see R3
    @(negedge i_scl) disable iff (i_sys_rst)
    stop_ev_c && !start_ev_c |=> link_ff.state == ST_IDLE &&
      link_ff.sda_oe_n)
    else $error("stop did not idle link");

  ack_released_a: assert property ( // see R4
    @(negedge i_scl) disable iff (i_sys_rst)
    link_ff.state inside {ST_AHI_ACK, ST_ALO_ACK, ST_WDAT_ACK} &&
      !start_ev_c && !stop_ev_c |-> !link_ff.sda_oe_n ##1
      link_ff.sda_oe_n)
    else $error("ack slot not one clock");

  // Checks on the timer side

  busy_hold_a: assert property ( // see R13
    @(posedge i_clock) disable iff (i_sys_rst)
    $rose(sys_ff.busy) |-> sys_ff.busy [*8])
    else $error("write cycle ended too soon");

  busy_end_a: assert property ( // see R5
    @(posedge i_clock) disable iff (i_sys_rst)
    sys_ff.busy && sys_ff.timer == 32'h0000_0000 |=> !sys_ff.busy)
    else $error("write cycle overran");

  busy_cause_a: assert property ( // see R13
    @(posedge i_clock) disable iff (i_sys_rst)
    $rose(sys_ff.busy) |-> $past(sys_stop_c) &&
      sys_ff.timer == 32'(WR_CYCLES - 1))
    else $error("write cycle without stop");

endmodule

/* File: shared/ee2w_pkg.sv */
// Purpose: Shared constants, types and state layout of the two-wire
//          EEPROM target.
// Assumes: System clock of 100 MHz; the link clock is the bus clock.
// Notes on behaviour
// R1: SDA change while SCL high is condition
// R2: SDA fall, SCL high, is start
// R3: SDA rise, SCL high, is stop
// R4: Target acks each received byte, ninth clock
// R5: Standby at power-up and after stop
// R6: Controller recovers bus with nine clocks, start
// R7: Device word starts with fixed five bits
// R8: Two select bits must match strap pins
// R9: Device word bit zero selects read/write
// R10: Ack on match, no ack on mismatch
// R11: Write protect high blocks all array writes
// R12: Write: two address bytes, data, stop
// R13: Self-timed write after stop, inputs ignored
// R14: Page write takes up to 128 bytes
// R15: Page write increments low seven bits only
// R16: Polled address acked only after write done
// R17: Address counter holds last address plus one
// R18: Read counter wraps from top to zero
// R19: Current read: ack, byte, no ack, stop
// R20: Random read uses dummy write, restart
// R21: Controller ack continues sequential read
// R22: Sample on SCL rise, drive after fall
// R23: Array is 512 pages of 128 bytes
// R24: Write protect low or open allows writes
// R25: Bits travel most significant first
// R26: Word address high byte goes first

package ee2w_pkg;

  // Array shape
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned PAGE_BITS = 7;
  localparam int unsigned MEM_BYTES = 65536;

  // Device address word layout
  localparam logic [4:0] DEV_PATTERN = 5'h14;
  localparam int unsigned DEV_PAT_LSB = 3;
  localparam int unsigned DEV_SEL_LSB = 1;
  localparam int unsigned DEV_RW_BIT = 0;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Self-timed write, in microseconds, and the clock rate
  localparam int unsigned CLK_FREQ_MHZ = 100;
  localparam int unsigned INTERNAL_WRITE_TIME_US = 10000;
  localparam int unsigned INTERNAL_WRITE_TIME_LOWV_US = 20000;
  localparam int unsigned WRITE_CYCLES =
    INTERNAL_WRITE_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned WRITE_CYCLES_LOWV =
    INTERNAL_WRITE_TIME_LOWV_US * CLK_FREQ_MHZ;

  // Link states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_DEV     = 4'b0001,
    ST_DEV_ACK = 4'b0010,
    ST_AHI     = 4'b0011,
    ST_AHI_ACK = 4'b0100,
    ST_ALO     = 4'b0101,
    ST_ALO_ACK = 4'b0110,
    ST_WDAT    = 4'b0111,
    ST_WDAT_ACK = 4'b1000,
    ST_RDAT    = 4'b1001,
    ST_RD_MACK = 4'b1010
  } ee2w_state_t;

  // Bus condition toggles from the data-edge detector
  typedef struct packed {
    logic start_tgl;
    logic stop_tgl;
  } ee2w_cond_t;

  // Pin levels carried across into the link domain
  typedef struct packed {
    logic busy;
    logic wp;
    logic [1:0] straps;
  } ee2w_pins_t;

  // Link-side state, clocked on the falling bus clock
  typedef struct packed {
    ee2w_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic rw;
    logic [7:0] addr_hi;
    logic [15:0] addr;
    logic first_data;
    logic wr_tgl;
    logic start_seen;
    logic stop_seen;
    ee2w_pins_t sync1;
    ee2w_pins_t sync2;
    logic sda_oe_n;
    logic sda_out;
    logic active;
  } ee2w_link_t;

  // System-side state
  typedef struct packed {
    logic stop_s1;
    logic stop_s2;
    logic wr_s1;
    logic wr_s2;
    logic stop_seen;
    logic wr_seen;
    logic busy;
    logic [31:0] timer;
  } ee2w_sys_t;

  localparam ee2w_link_t LINK_RST = '{
    state: ST_IDLE, sda_oe_n: 1'b1, default: '0};
  localparam ee2w_sys_t SYS_RST = '{default: '0};

endpackage

/* File: tb/ee2w_ctrl_model.sv */
// Purpose: Bus controller model that drives the serial clock and data.
// Assumes: Data line has a pull-up; a released line reads high.
// Notes: Serial clock stands high between frames; 48 ns bit period.
`timescale 1ns/100ps

module ee2w_ctrl_model (
  // Resolved data wire
  input wire logic i_sda,
  // Driven bus pins
  output logic o_scl,
  output logic o_sda
);
  localparam int Q = 12;

  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Data moves only while the clock is low
  task automatic clk_bit(input logic b, output logic r);
    o_sda = b;
    #Q o_scl = 1'b1;
    #Q r = i_sda;
    #Q o_scl = 1'b0;
    #Q;
  endtask

  // Also serves as a repeated start from clock low
  task automatic start_cond();
    o_sda = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b0;
    #Q;
  endtask

  // Clock is left standing high afterwards
  task automatic stop_cond();
    o_sda = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b1;
    #(2 * Q);
  endtask

  // Most significant bit first, then the ack slot
  task automatic wr_byte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, nack);
  endtask

  // Controller ack low continues a read, high ends it
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(nack, r);
  endtask

  // Up to nine clocks, start once data is seen high
  task automatic recover();
    logic done;
    done = 1'b0;
    for (int i = 0; i < 9 && !done; i++) begin
      o_sda = 1'b1;
      #Q o_scl = 1'b1;
      #Q done = i_sda;
      if (done) o_sda = 1'b0;
      #Q o_scl = 1'b0;
      #Q;
    end
    stop_cond();
  endtask
endmodule

/* File: tb/tb_ee2w_target.sv */
// Purpose: Self-checking bench for the two-wire EEPROM target.
// Assumes: Straps tied to 10; write timer shortened to WR cycles.
// Notes: Timer is long enough that a poll lands inside the write.
`timescale 1ns/100ps

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  n_mismatch++; \
  $display("MISMATCH at %0t: got %h want %h", $time, a, b); end end

module tb_ee2w_target;
  import ee2w_pkg::*;
  localparam int unsigned WR = 200;
  localparam logic [7:0] DEV = 8'hA4;
  localparam logic [7:0] DEV_RD = 8'hA5;
  logic i_clock = 1'b0;
  logic i_sys_rst;
  logic [1:0] straps;
  logic wp;
  logic scl;
  logic ctrl_sda;
  logic sda_out;
  logic sda_oe_n;
  logic write_busy;
  logic link_active;
  wire sda = ctrl_sda & (sda_oe_n | sda_out);
  int n_mismatch = 0;
  int n_checks = 0;
  int busy_len = 0;

  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) if (write_busy === 1'b1) busy_len++;

  ee2w_ctrl_model ee2w_ctrl_model_i (
    .i_sda(sda),
    .o_scl(scl),
    .o_sda(ctrl_sda)
  );

  ee2w_target #(.WR_CYCLES(WR)) ee2w_target_i (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_scl(scl),
    .i_sda_in(sda),
    .o_sda_out(sda_out),
    .o_sda_oe_n(sda_oe_n),
    .i_device_select_straps(straps),
    .i_write_protect(wp),
    .o_write_busy(write_busy),
    .o_link_active(link_active)
  );

  task automatic stop_test();
    $display("Checks: %0d mismatches: %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic exp);
    logic n;
    ee2w_ctrl_model_i.wr_byte(b, n);
    `CHK(n, exp)
  endtask

  task automatic get(input logic nack, input logic [7:0] exp);
    logic [7:0] d;
    ee2w_ctrl_model_i.rd_byte(nack, d);
    `CHK(d, exp)
  endtask

  task automatic point(input logic [15:0] a);
    ee2w_ctrl_model_i.start_cond();
    send(DEV, 1'b0);
    send(a[15:8], 1'b0);
    send(a[7:0], 1'b0);
    `CHK(link_active, 1'b1)
  endtask

  // Restart and read, as a random read does
  task automatic read_from(input logic [15:0] a);
    point(a);
    ee2w_ctrl_model_i.start_cond();
    send(DEV_RD, 1'b0);
  endtask

  task automatic finish_write(input logic poll);
    int k;
    busy_len = 0;
    ee2w_ctrl_model_i.stop_cond();
    repeat (10) @(negedge i_clock);
    `CHK(write_busy, 1'b1)
    if (poll) begin
      ee2w_ctrl_model_i.start_cond();
      send(DEV, 1'b1);
    end
    k = 0;
    while (write_busy !== 1'b0 && k < 4 * WR) begin
      @(negedge i_clock);
      k++;
    end
    `CHK(busy_len, WR)
  endtask

  task automatic s_reset();
    `CHK(sda_oe_n, 1'b1)
    `CHK(write_busy, 1'b0)
    `CHK(link_active, 1'b0)
  endtask

  // Each flipped bit of the pattern or selects is refused
  task automatic s_mismatch();
    for (int i = 1; i < 8; i++) begin
      ee2w_ctrl_model_i.start_cond();
      send(DEV ^ (8'h01 << i), 1'b1);
    end
    send(DEV, 1'b1);
    `CHK(link_active, 1'b0)
    ee2w_ctrl_model_i.stop_cond();
  endtask

  task automatic s_byte();
    point(16'h1234);
    send(8'h5A, 1'b0);
    finish_write(1'b1);
    read_from(16'h1234);
    get(1'b1, 8'h5A);
    ee2w_ctrl_model_i.stop_cond();
    `CHK(link_active, 1'b0)
  endtask

  // Third byte wraps to the start of the page
  task automatic s_page();
    point(16'h207E);
    send(8'hA1, 1'b0);
    send(8'hB2, 1'b0);
    send(8'hC3, 1'b0);
    finish_write(1'b0);
    read_from(16'h207E);
    get(1'b0, 8'hA1);
    get(1'b1, 8'hB2);
    ee2w_ctrl_model_i.stop_cond();
    read_from(16'h2000);
    get(1'b1, 8'hC3);
    ee2w_ctrl_model_i.stop_cond();
  endtask

  // Counter runs over the top; then a read is abandoned just after an ack
  task automatic s_wrap();
    point(16'hFFFF);
    send(8'h11, 1'b0);
    finish_write(1'b0);
    point(16'h0000);
    send(8'h22, 1'b0);
    send(8'h00, 1'b0);
    finish_write(1'b0);
    read_from(16'hFFFF);
    get(1'b1, 8'h11);
    ee2w_ctrl_model_i.stop_cond();
    ee2w_ctrl_model_i.start_cond();
    send(DEV_RD, 1'b0);
    get(1'b0, 8'h22);
    ee2w_ctrl_model_i.recover();
    read_from(16'h0000);
    get(1'b1, 8'h22);
    ee2w_ctrl_model_i.stop_cond();
  endtask

  task automatic s_protect();
    wp = 1'b1;
    point(16'h2000);
    send(8'h99, 1'b0);
    ee2w_ctrl_model_i.stop_cond();
    repeat (40) @(negedge i_clock);
    `CHK(write_busy, 1'b0)
    wp = 1'b0;
    read_from(16'h2000);
    get(1'b1, 8'hC3);
    ee2w_ctrl_model_i.stop_cond();
  endtask

  initial begin
    i_sys_rst = 1'b1;
    wp = 1'b0;
    straps = 2'b10;
    repeat (5) @(negedge i_clock);
    i_sys_rst = 1'b0;
    repeat (2) @(negedge i_clock);
    s_reset();
    s_mismatch();
    s_byte();
    s_page();
    s_wrap();
    s_protect();
    stop_test();
  end

  // Whole run needs well under 100 us
  initial begin
    #300000;
    n_mismatch++;
    stop_test();
  end
endmodule
